// File: logic/cmmp_pkg.sv
package cmmp_pkg;
    localparam int PC_W = 13;
    localparam int PROG_AW = 12;
    localparam int INSTR_W = 14;
    localparam int DATA_W = 8;
    localparam int FILE_AW = 9;
    localparam int OFF_W = 7;
    localparam int APB_AW = 8;
    localparam int APB_DW = 32;
    localparam int IDX_W = 6;

    localparam logic [12:0] RESET_VECTOR = 13'h0000;
    localparam logic [12:0] IRQ_VECTOR = 13'h0004;
    localparam logic [12:0] PC_STEP = 13'h0001;
    localparam logic [13:0] NOP_WORD = 14'h0000;

    // Offsets inside any bank, those below 20h also the register indexes on the bus
    localparam logic [6:0] OFF_INDIRECT = 7'h00;
    localparam logic [6:0] OFF_PC_LOW = 7'h02;
    localparam logic [6:0] OFF_STATUS = 7'h03;
    localparam logic [6:0] OFF_IND_PTR = 7'h04;
    localparam logic [6:0] OFF_PC_HIGH_LATCH = 7'h0a;
    localparam logic [6:0] OFF_INT_CTRL = 7'h0b;
    localparam logic [6:0] OFF_GPR_BASE = 7'h20;
    localparam logic [6:0] OFF_COMMON_BASE = 7'h70;
    localparam logic [1:0] COMMON_BANK = 2'h0;

    localparam logic [5:0] IDX_CTRL = 6'h10;
    localparam logic [5:0] IDX_PC_FULL = 6'h11;

    localparam int ST_IND_BANK = 7;
    localparam int ST_BANK_HIGH = 6;
    localparam int ST_BANK_LOW = 5;
    localparam logic [7:0] STATUS_RESET = 8'h18;
    localparam logic [7:0] STATUS_WR_MASK = 8'he7;
    localparam logic [7:0] PC_LOW_RESET = 8'h00;
    localparam logic [7:0] IND_PTR_RESET = 8'h00;
    localparam logic [7:0] PC_HIGH_LATCH_RESET = 8'h00;
    localparam logic [7:0] INT_CTRL_RESET = 8'h00;
    localparam int CTRL_RUN_BIT = 0;
    localparam logic CTRL_RUN_RESET = 1'b1;
    localparam int PC_HIGH_USED_W = 5;

    typedef enum logic [1:0] {
        CMMP_PH_ONE = 2'b00,
        CMMP_PH_TWO = 2'b01,
        CMMP_PH_THREE = 2'b10,
        CMMP_PH_FOUR = 2'b11
    } cmmp_phase_t;
endpackage

// File: logic/cmmp_phase_gen.sv
`timescale 1ns/100ps
module cmmp_phase_gen
    import cmmp_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic run,
    output logic phase_one,
    output logic phase_two,
    output logic phase_three,
    output logic phase_four
);
    cmmp_phase_t phase_reg;
    cmmp_phase_t phase_next;

    // Stopped core parks in phase one so a restart is a clean cycle
    always_comb begin
        phase_next = CMMP_PH_ONE;
        if (run) begin
            case (phase_reg)
                CMMP_PH_ONE: phase_next = CMMP_PH_TWO;
                CMMP_PH_TWO: phase_next = CMMP_PH_THREE;
                CMMP_PH_THREE: phase_next = CMMP_PH_FOUR;
                CMMP_PH_FOUR: phase_next = CMMP_PH_ONE;
                default: phase_next = CMMP_PH_ONE;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            phase_reg <= CMMP_PH_ONE;
        end else begin
            phase_reg <= phase_next;
        end
    end

    assign phase_one = run && (phase_reg == CMMP_PH_ONE);
    assign phase_two = run && (phase_reg == CMMP_PH_TWO);
    assign phase_three = run && (phase_reg == CMMP_PH_THREE);
    assign phase_four = run && (phase_reg == CMMP_PH_FOUR);
endmodule // cmmp_phase_gen

// File: logic/cmmp_file_ram.sv
`timescale 1ns/100ps
module cmmp_file_ram #(
    parameter int AW = 9,
    parameter int DW = 8
) (
    input wire logic pclk,
    input wire logic rd_en,
    input wire logic [AW-1:0] rd_addr,
    output logic [DW-1:0] rd_data,
    input wire logic wr_en,
    input wire logic [AW-1:0] wr_addr,
    input wire logic [DW-1:0] wr_data
);
    logic [DW-1:0] mem [0:(1<<AW)-1];

    // Register file contents are undefined after reset, as in the map
    always_ff @(posedge pclk) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
    end

    always_ff @(posedge pclk) begin
        if (rd_en) begin
            rd_data <= mem[rd_addr];
        end
    end
endmodule // cmmp_file_ram

// File: logic/cmmp_core.sv
// The APB interface to the registers is this design's own decision.
`timescale 1ns/100ps
module cmmp_core
    import cmmp_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [APB_AW-1:0] paddr,
    input wire logic [APB_DW-1:0] pwdata,
    output logic [APB_DW-1:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic [PROG_AW-1:0] prog_addr,
    input wire logic [INSTR_W-1:0] instr_in,
    output logic [INSTR_W-1:0] exec_instr,
    output logic exec_valid,
    output logic phase_one,
    output logic phase_two,
    output logic phase_three,
    output logic phase_four,
    input wire logic [OFF_W-1:0] exec_file_addr,
    input wire logic exec_indirect,
    input wire logic exec_rd_en,
    output logic [DATA_W-1:0] exec_rd_data,
    input wire logic exec_wr_en,
    input wire logic [DATA_W-1:0] exec_wr_data,
    input wire logic exec_branch,
    input wire logic [PC_W-1:0] exec_branch_target,
    input wire logic irq_take
);
    logic [PC_W-1:0] pc_reg;
    logic [PROG_AW-1:0] fetch_addr_reg;
    logic [INSTR_W-1:0] fetch_word_reg;
    logic [INSTR_W-1:0] exec_instr_reg;
    logic exec_valid_reg;
    logic flush_reg;
    logic [DATA_W-1:0] status_reg;
    logic [DATA_W-1:0] indirect_pointer_reg;
    logic [DATA_W-1:0] program_counter_high_latch_reg;
    logic [DATA_W-1:0] interrupt_control_reg;
    logic run_reg;
    logic [DATA_W-1:0] rd_core_reg;
    logic rd_core_sel_reg;
    logic [APB_DW-1:0] prdata_reg;
    logic boot_reg;
    logic [FILE_AW-1:0] eff_addr;
    logic [OFF_W-1:0] eff_off;
    logic [FILE_AW-1:0] ram_addr;
    logic eff_is_core;
    logic eff_is_ram;
    logic [DATA_W-1:0] ram_rd_data;
    logic ram_rd_en;
    logic ram_wr_en;
    logic cpu_wr;
    logic cpu_pc_low_wr;
    logic cpu_pc_load;
    logic [PC_W-1:0] cpu_pc_target;
    logic [PC_W-1:0] wr_pc_target;
    logic apb_access;
    logic apb_setup;
    logic [IDX_W-1:0] apb_idx;
    logic apb_hit;
    logic apb_wr;
    logic apb_pc_load;

    cmmp_phase_gen u_phase (
        .pclk(pclk),
        .presetn(presetn),
        .run(run_reg),
        .phase_one(phase_one),
        .phase_two(phase_two),
        .phase_three(phase_three),
        .phase_four(phase_four)
    );

    function automatic logic off_is_core(input logic [OFF_W-1:0] off);
        off_is_core = (off == OFF_INDIRECT) || (off == OFF_PC_LOW) ||
                      (off == OFF_STATUS) || (off == OFF_IND_PTR) ||
                      (off == OFF_PC_HIGH_LATCH) || (off == OFF_INT_CTRL);
    endfunction

    // Core register view, identical from every bank
    function automatic logic [DATA_W-1:0] core_value(
        input logic [OFF_W-1:0] off
    );
        core_value = '0;
        if (off == OFF_PC_LOW) begin
            core_value = pc_reg[DATA_W-1:0];
        end else if (off == OFF_STATUS) begin
            core_value = status_reg;
        end else if (off == OFF_IND_PTR) begin
            core_value = indirect_pointer_reg;
        end else if (off == OFF_PC_HIGH_LATCH) begin
            core_value = program_counter_high_latch_reg;
        end else if (off == OFF_INT_CTRL) begin
            core_value = interrupt_control_reg;
        end
    endfunction

    // Direct offset 00h goes through the pointer; pointer to 00h reads 0
    always_comb begin
        if (exec_indirect || exec_file_addr == OFF_INDIRECT) begin
            eff_addr = {status_reg[ST_IND_BANK], indirect_pointer_reg};
        end else begin
            eff_addr = {status_reg[ST_BANK_HIGH], status_reg[ST_BANK_LOW],
                        exec_file_addr};
        end
    end

    assign eff_off = eff_addr[OFF_W-1:0];
    assign eff_is_core = off_is_core(eff_off);
    assign eff_is_ram = (eff_off >= OFF_GPR_BASE);
    // Shared tops of banks 1-3 reuse bank 0 cells
    assign ram_addr = (eff_off >= OFF_COMMON_BASE) ?
                      {COMMON_BANK, eff_off} : eff_addr;

    assign ram_rd_en = phase_two && exec_rd_en && eff_is_ram;
    assign cpu_wr = phase_four && exec_wr_en;
    assign ram_wr_en = cpu_wr && eff_is_ram;

    cmmp_file_ram #(
        .AW(FILE_AW),
        .DW(DATA_W)
    ) u_ram (
        .pclk(pclk),
        .rd_en(ram_rd_en),
        .rd_addr(ram_addr),
        .rd_data(ram_rd_data),
        .wr_en(ram_wr_en),
        .wr_addr(ram_addr),
        .wr_data(exec_wr_data)
    );

    // Non-RAM reads capture core value; peripheral holes read as zero
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rd_core_reg <= '0;
            rd_core_sel_reg <= 1'b1;
        end else if (phase_two && exec_rd_en) begin
            rd_core_reg <= eff_is_core ? core_value(eff_off) : '0;
            rd_core_sel_reg <= !eff_is_ram;
        end
    end

    assign exec_rd_data = rd_core_sel_reg ? rd_core_reg : ram_rd_data;

    // Program counter changes from the executing instruction
    assign cpu_pc_low_wr = cpu_wr && eff_is_core && (eff_off == OFF_PC_LOW);
    assign wr_pc_target = {
        program_counter_high_latch_reg[PC_HIGH_USED_W-1:0], exec_wr_data};
    assign cpu_pc_load = phase_four && (irq_take || exec_branch ||
                                        cpu_pc_low_wr);
    always_comb begin
        if (irq_take) begin
            cpu_pc_target = IRQ_VECTOR;
        end else if (exec_branch) begin
            cpu_pc_target = exec_branch_target;
        end else begin
            cpu_pc_target = wr_pc_target;
        end
    end

    // Bus slave: zero wait states, read data staged in the setup cycle
    assign apb_setup = psel && !penable;
    assign apb_access = psel && penable;
    assign apb_idx = paddr[APB_AW-1:2];
    assign apb_hit = (paddr[1:0] == 2'b00) &&
                     (off_is_core({1'b0, apb_idx}) || apb_idx == IDX_CTRL ||
                      apb_idx == IDX_PC_FULL);
    assign apb_wr = apb_access && pwrite && apb_hit;
    assign apb_pc_load = apb_wr && (apb_idx == OFF_PC_LOW[IDX_W-1:0]);
    assign pready = 1'b1;
    assign pslverr = apb_access && !apb_hit;
    assign prdata = prdata_reg;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_reg <= '0;
        end else if (apb_setup && !pwrite) begin
            if (apb_idx == IDX_CTRL) begin
                prdata_reg <= {{(APB_DW-1){1'b0}}, run_reg};
            end else if (apb_idx == IDX_PC_FULL) begin
                prdata_reg <= {{(APB_DW-PC_W){1'b0}}, pc_reg};
            end else if (off_is_core({1'b0, apb_idx})) begin
                prdata_reg <= {{(APB_DW-DATA_W){1'b0}},
                               core_value({1'b0, apb_idx})};
            end else begin
                prdata_reg <= '0;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            run_reg <= CTRL_RUN_RESET;
        end else if (apb_wr && apb_idx == IDX_CTRL) begin
            run_reg <= pwdata[CTRL_RUN_BIT];
        end
    end

    // Core registers: the CPU write in phase four wins over the bus
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            status_reg <= STATUS_RESET;
        end else if (cpu_wr && eff_is_core && eff_off == OFF_STATUS) begin
            status_reg <= (status_reg & ~STATUS_WR_MASK) |
                          (exec_wr_data & STATUS_WR_MASK);
        end else if (apb_wr && apb_idx == OFF_STATUS[IDX_W-1:0]) begin
            status_reg <= (status_reg & ~STATUS_WR_MASK) |
                          (pwdata[DATA_W-1:0] & STATUS_WR_MASK);
        end
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            indirect_pointer_reg <= IND_PTR_RESET;
        end else if (cpu_wr && eff_is_core && eff_off == OFF_IND_PTR) begin
            indirect_pointer_reg <= exec_wr_data;
        end else if (apb_wr && apb_idx == OFF_IND_PTR[IDX_W-1:0]) begin
            indirect_pointer_reg <= pwdata[DATA_W-1:0];
        end
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            program_counter_high_latch_reg <= PC_HIGH_LATCH_RESET;
        end else if (cpu_wr && eff_is_core &&
                     eff_off == OFF_PC_HIGH_LATCH) begin
            program_counter_high_latch_reg <= exec_wr_data;
        end else if (apb_wr && apb_idx == OFF_PC_HIGH_LATCH[IDX_W-1:0]) begin
            program_counter_high_latch_reg <= pwdata[DATA_W-1:0];
        end
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            interrupt_control_reg <= INT_CTRL_RESET;
        end else if (cpu_wr && eff_is_core && eff_off == OFF_INT_CTRL) begin
            interrupt_control_reg <= exec_wr_data;
        end else if (apb_wr && apb_idx == OFF_INT_CTRL[IDX_W-1:0]) begin
            interrupt_control_reg <= pwdata[DATA_W-1:0];
        end
    end

    // Program counter: loads win over the phase-one step
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pc_reg <= RESET_VECTOR;
        end else if (cpu_pc_load) begin
            pc_reg <= cpu_pc_target;
        end else if (apb_pc_load) begin
            pc_reg <= {program_counter_high_latch_reg[PC_HIGH_USED_W-1:0],
                       pwdata[DATA_W-1:0]};
        end else if (phase_one) begin
            pc_reg <= pc_reg + PC_STEP;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fetch_addr_reg <= RESET_VECTOR[PROG_AW-1:0];
            fetch_word_reg <= NOP_WORD;
        end else begin
            if (phase_one) begin
                fetch_addr_reg <= pc_reg[PROG_AW-1:0];
            end
            if (phase_four) begin
                fetch_word_reg <= instr_in;
            end
        end
    end
    assign prog_addr = fetch_addr_reg;
    // Nothing is prefetched at reset, so the first slot is a no-op too
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flush_reg <= 1'b1;
        end else if (cpu_pc_load || apb_pc_load) begin
            flush_reg <= 1'b1;
        end else if (phase_one) begin
            flush_reg <= 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            exec_instr_reg <= NOP_WORD;
            exec_valid_reg <= 1'b0;
        end else if (phase_one) begin
            exec_instr_reg <= flush_reg ? NOP_WORD : fetch_word_reg;
            exec_valid_reg <= !flush_reg;
        end
    end
    assign exec_instr = exec_instr_reg;
    assign exec_valid = exec_valid_reg;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            boot_reg <= 1'b1;
        end else begin
            boot_reg <= 1'b0;
        end
    end

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence s_rest_of_cycle;
        phase_two ##1 phase_three ##1 phase_four;
    endsequence
    sequence s_branch_taken;
        phase_four && (exec_branch || irq_take);
    endsequence
    // A stop in mid-cycle cuts the rotation on purpose
    phase_order_a: assert property (
        disable iff (!presetn || !run_reg)
        phase_one |=> s_rest_of_cycle)
        else $error("phase order broken");
    pc_step_a: assert property (
        (phase_one && !cpu_pc_load && !apb_pc_load) |=>
            pc_reg == $past(pc_reg) + PC_STEP)
        else $error("pc did not step in phase one");
    fetch_wrap_a: assert property (
        phase_one |=> fetch_addr_reg == $past(pc_reg[PROG_AW-1:0]))
        else $error("fetch address not wrapped pc");
    reset_vector_a: assert property (
        boot_reg |-> pc_reg == RESET_VECTOR && flush_reg)
        else $error("reset did not load reset vector");
    irq_vector_a: assert property (
        (phase_four && irq_take) |=> pc_reg == IRQ_VECTOR)
        else $error("interrupt did not load vector");
    branch_flush_a: assert property (
        s_branch_taken ##1 phase_one |=>
            exec_instr_reg == NOP_WORD && !exec_valid_reg)
        else $error("prefetched word not flushed");
    single_cycle_a: assert property (
        (phase_one && !flush_reg) |=>
            exec_valid_reg && exec_instr_reg == $past(fetch_word_reg))
        else $error("instruction not issued in one cycle");
    bank_select_a: assert property (
        (!exec_indirect && exec_file_addr != OFF_INDIRECT) |->
            eff_addr[FILE_AW-1:OFF_W] ==
            {status_reg[ST_BANK_HIGH], status_reg[ST_BANK_LOW]})
        else $error("bank bits not used for direct access");
    common_map_a: assert property (
        (eff_off >= OFF_COMMON_BASE) |->
            ram_addr[FILE_AW-1:OFF_W] == COMMON_BANK)
        else $error("shared location not mapped to bank 0");
    mirror_read_a: assert property (
        (phase_two && exec_rd_en && eff_off == OFF_STATUS) |=>
            exec_rd_data == $past(status_reg))
        else $error("status not mirrored in this bank");
    write_phase_a: assert property (
        ram_wr_en |-> phase_four && $past(phase_three))
        else $error("data write outside phase four");
endmodule // cmmp_core

// File: verif/cmmp_cpu_model.sv
`timescale 1ns/100ps
module cmmp_cpu_model
    import cmmp_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [PROG_AW-1:0] prog_addr,
    output logic [INSTR_W-1:0] instr_in,
    input wire logic phase_four,
    input wire logic [DATA_W-1:0] exec_rd_data,
    input wire logic [OFF_W-1:0] c_off,
    input wire logic c_ind,
    input wire logic c_rd,
    input wire logic c_wr,
    input wire logic [DATA_W-1:0] c_wdata,
    input wire logic c_br,
    input wire logic [PC_W-1:0] c_tgt,
    input wire logic c_irq,
    output logic [OFF_W-1:0] exec_file_addr,
    output logic exec_indirect,
    output logic exec_rd_en,
    output logic exec_wr_en,
    output logic [DATA_W-1:0] exec_wr_data,
    output logic exec_branch,
    output logic [PC_W-1:0] exec_branch_target,
    output logic irq_take,
    output logic [DATA_W-1:0] rd_seen
);
    // Word tied to its address so every fetch can be told apart
    assign instr_in = {2'b10, prog_addr};

    // Requests change only at a cycle boundary and stand for four phases
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            exec_file_addr <= '0;
            exec_indirect <= 1'h0;
            exec_rd_en <= 1'h0;
            exec_wr_en <= 1'h0;
            exec_wr_data <= '0;
            exec_branch <= 1'h0;
            exec_branch_target <= '0;
            irq_take <= 1'h0;
            rd_seen <= '0;
        end else if (phase_four) begin
            exec_file_addr <= c_off;
            exec_indirect <= c_ind;
            exec_rd_en <= c_rd;
            exec_wr_en <= c_wr;
            // Idle data toggles, so a stray write never looks plausible
            exec_wr_data <= c_wr ? c_wdata : ~exec_wr_data;
            exec_branch <= c_br;
            exec_branch_target <= c_br ? c_tgt : ~exec_branch_target;
            irq_take <= c_irq;
            rd_seen <= exec_rd_data;
        end
    end
endmodule // cmmp_cpu_model

// File: verif/core_memory_map_pipeline_test.sv
`timescale 1ns/100ps
module core_memory_map_pipeline_test
    import cmmp_pkg::*;
;
    typedef struct packed {
        logic [1:0] ab; logic [6:0] ao; logic [7:0] ad;
        logic [1:0] bb; logic [6:0] bo; logic [7:0] bd;
        logic [1:0] rb; logic [6:0] ro; logic ri; logic rw; logic [7:0] ex;
    } cmmp_row_t;
    cmmp_row_t rows[8] = '{
        '{2'h1,7'h30,8'h33,2'h0,7'h30,8'h44,2'h1,7'h30,1'h0,1'h0,8'h33},
        '{2'h3,7'h75,8'hc3,2'h2,7'h76,8'hc4,2'h0,7'h75,1'h0,1'h0,8'hc3},
        '{2'h2,7'h04,8'h9e,2'h0,7'h2f,8'h00,2'h1,7'h04,1'h0,1'h0,8'h9e},
        '{2'h3,7'h0a,8'h15,2'h0,7'h0b,8'h42,2'h1,7'h0a,1'h0,1'h0,8'h15},
        '{2'h0,7'h04,8'h45,2'h1,7'h00,8'h77,2'h2,7'h5e,1'h1,1'h0,8'h77},
        '{2'h1,7'h7f,8'hb2,2'h0,7'h2f,8'h00,2'h3,7'h7f,1'h0,1'h1,8'hb2},
        '{2'h0,7'h20,8'h00,2'h0,7'h21,8'h00,2'h0,7'h7f,1'h0,1'h0,8'hb3},
        '{2'h0,7'h20,8'h00,2'h0,7'h21,8'h00,2'h3,7'h03,1'h0,1'h0,8'h78}};
    logic [5:0] ridx[6] = '{6'h03, 6'h04, 6'h0a, 6'h0b, 6'h00, 6'h3f};
    logic [31:0] rexp[6] = '{32'h18, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0};
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [APB_AW-1:0] paddr;
    logic [APB_DW-1:0] pwdata, prdata, rdv;
    logic [PROG_AW-1:0] prog_addr;
    logic [INSTR_W-1:0] instr_in, exec_instr;
    logic exec_valid, phase_one, phase_two, phase_three, phase_four;
    logic [OFF_W-1:0] exec_file_addr, c_off;
    logic exec_indirect, exec_rd_en, exec_wr_en, exec_branch, irq_take;
    logic [DATA_W-1:0] exec_rd_data, exec_wr_data, c_wdata, rd_seen;
    logic [PC_W-1:0] exec_branch_target, c_tgt;
    logic c_ind, c_rd, c_wr, c_br, c_irq, erv;
    logic [1:0] cur_bank;
    logic any_phase;
    assign any_phase = phase_one | phase_two | phase_three | phase_four;
    int mismatches, cmp_count, cycles, t0;

    cmmp_core u_cmmp_core (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
        .pwdata, .prdata, .pready, .pslverr, .prog_addr, .instr_in,
        .exec_instr, .exec_valid, .phase_one, .phase_two, .phase_three,
        .phase_four, .exec_file_addr, .exec_indirect, .exec_rd_en,
        .exec_rd_data, .exec_wr_en, .exec_wr_data, .exec_branch,
        .exec_branch_target, .irq_take);
    cmmp_cpu_model u_cmmp_cpu_model (.pclk, .presetn, .prog_addr, .instr_in,
        .phase_four, .exec_rd_data, .c_off, .c_ind, .c_rd, .c_wr, .c_wdata,
        .c_br, .c_tgt, .c_irq, .exec_file_addr, .exec_indirect, .exec_rd_en,
        .exec_wr_en, .exec_wr_data, .exec_branch, .exec_branch_target,
        .irq_take, .rd_seen);

    initial begin
        pclk = 1'h0;
        forever #5 pclk = ~pclk;
    end

    task automatic give_verdict();
        $display("comparisons %0d, mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    // Generous ceiling: the whole sequence needs well under a thousand
    always @(posedge pclk) begin
        cycles++;
        if (cycles == 20000) begin
            mismatches++;
            give_verdict();
        end
    end

    task automatic chk_reg(input string name, input logic [31:0] exp, got);
        cmp_count++;
        if (got !== exp) begin
            mismatches++;
            $display("unexpected %s: expected %h, seen %h", name, exp, got);
        end
    endtask

    task automatic chk_pipe(input string name, input logic [13:0] exp, got);
        cmp_count++;
        if (got !== exp) begin
            mismatches++;
            $display("unexpected %s: expected %h, seen %h", name, exp, got);
        end
    endtask

    function automatic logic [13:0] word(input logic [11:0] a);
        return {2'b10, a};
    endfunction

    task automatic apb_xfer(input logic wr, input logic [5:0] idx,
        input logic [31:0] wd, output logic [31:0] rd, output logic err);
        @(posedge pclk);
        psel <= 1'h1;
        penable <= 1'h0;
        pwrite <= wr;
        paddr <= {idx, 2'b00};
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'h1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask

    task automatic wait_p1();
        do @(posedge pclk); while (phase_one !== 1'b1);
        #1;
    endtask

    task automatic wait_p4();
        do @(posedge pclk); while (phase_four !== 1'b1);
    endtask

    task automatic cpu_op(input logic [1:0] bank, input logic [6:0] off,
        input logic ind, rd, wr, input logic [7:0] wd, input logic br, irq,
        input logic [12:0] tgt);
        logic [31:0] d;
        logic e;
        if (bank !== cur_bank)
            apb_xfer(1'h1, OFF_STATUS[5:0], {25'h0, bank, 5'h00}, d, e);
        cur_bank = bank;
        @(posedge pclk);
        {c_off, c_ind, c_rd, c_wr, c_wdata} <= {off, ind, rd, wr, wd};
        {c_br, c_irq, c_tgt} <= {br, irq, tgt};
        wait_p4();
        {c_off, c_ind, c_rd, c_wr, c_wdata, c_br, c_irq, c_tgt} <= '0;
        wait_p4();
        #1;
    endtask

    initial begin
        {psel, penable, pwrite, paddr, pwdata} = '0;
        {c_off, c_ind, c_rd, c_wr, c_wdata, c_br, c_irq, c_tgt} = '0;
        presetn = 1'h0;
        cur_bank = 2'h0;
        repeat (2) @(posedge pclk);
        #1;
        chk_pipe("fetch address in reset", 14'h0, {2'h0, prog_addr});
        chk_pipe("valid in reset", 14'h0, {13'h0, exec_valid});
        chk_pipe("phase one in reset", 14'h1, {13'h0, phase_one});
        chk_pipe("ready in reset", 14'h1, {13'h0, pready});
        @(posedge pclk);
        presetn <= 1'h1;
        wait_p1();
        wait_p1();
        t0 = cycles;
        chk_pipe("first word", word(12'h000), exec_instr);
        chk_pipe("next fetch", 14'h1, {2'h0, prog_addr});
        wait_p1();
        chk_pipe("second word", word(12'h001), exec_instr);
        chk_pipe("cycle length", 14'h4, 14'(cycles - t0));
        $display("test reset_and_flow done");
        for (int i = 0; i < 6; i++) begin
            apb_xfer(1'h0, ridx[i], 32'h0, rdv, erv);
            chk_reg("reset value", rexp[i], rdv);
            chk_reg("slave error", {31'h0, i == 5}, {31'h0, erv});
        end
        apb_xfer(1'h1, OFF_STATUS[5:0], 32'h0, rdv, erv);
        apb_xfer(1'h0, OFF_STATUS[5:0], 32'h0, rdv, erv);
        chk_reg("status read-only bits", 32'h18, rdv);
        $display("test register_reset done");
        foreach (rows[i]) begin
            cpu_op(rows[i].ab, rows[i].ao, 1'h0, 1'h0, 1'h1, rows[i].ad,
                1'h0, 1'h0, 13'h0);
            cpu_op(rows[i].bb, rows[i].bo, 1'h0, 1'h0, 1'h1, rows[i].bd,
                1'h0, 1'h0, 13'h0);
            cpu_op(rows[i].rb, rows[i].ro, rows[i].ri, 1'h1, rows[i].rw,
                rows[i].ex + 8'h01, 1'h0, 1'h0, 13'h0);
            chk_reg("file read", {24'h0, rows[i].ex}, {24'h0, rd_seen});
        end
        $display("test file_map done");
        cpu_op(cur_bank, 7'h0, 1'h0, 1'h0, 1'h0, 8'h0, 1'h1, 1'h0, 13'h1005);
        wait_p1();
        chk_pipe("flushed slot", 14'h0, exec_instr);
        chk_pipe("flushed valid", 14'h0, {13'h0, exec_valid});
        chk_pipe("wrapped fetch", 14'h5, {2'h0, prog_addr});
        apb_xfer(1'h0, IDX_PC_FULL, 32'h0, rdv, erv);
        chk_reg("full counter", 32'h1006, rdv);
        wait_p1();
        chk_pipe("target word", word(12'h005), exec_instr);
        chk_pipe("target valid", 14'h1, {13'h0, exec_valid});
        $display("test branch_flush done");
        cpu_op(cur_bank, 7'h0, 1'h0, 1'h0, 1'h0, 8'h0, 1'h1, 1'h1, 13'h0200);
        wait_p1();
        chk_pipe("vector fetch", 14'h4, {2'h0, prog_addr});
        wait_p1();
        chk_pipe("vector word", word(12'h004), exec_instr);
        $display("test interrupt_entry done");
        cpu_op(cur_bank, 7'h02, 1'h0, 1'h0, 1'h1, 8'h40, 1'h0, 1'h0, 13'h0);
        wait_p1();
        chk_pipe("low byte jump", 14'h540, {2'h0, prog_addr});
        chk_pipe("jump flushed", 14'h0, {13'h0, exec_valid});
        $display("test low_byte_jump done");
        apb_xfer(1'h1, IDX_CTRL, 32'h0, rdv, erv);
        repeat (4) @(posedge pclk);
        chk_pipe("halted phases", 14'h0, {13'h0, any_phase});
        apb_xfer(1'h0, IDX_CTRL, 32'h0, rdv, erv);
        chk_reg("run flag", 32'h0, rdv);
        apb_xfer(1'h1, IDX_CTRL, 32'h1, rdv, erv);
        #1;
        chk_pipe("restart phase", 14'h1, {13'h0, phase_one});
        $display("test run_control done");
        @(posedge pclk);
        presetn <= 1'h0;
        repeat (2) @(posedge pclk);
        chk_pipe("mid-run reset", 14'h0, {2'h0, prog_addr});
        presetn <= 1'h1;
        wait_p1();
        wait_p1();
        chk_pipe("word after reset", word(12'h000), exec_instr);
        $display("test reset_again done");
        give_verdict();
    end
endmodule // core_memory_map_pipeline_test
